//--- rtl/ptm_bank.sv
// preset 1 threshold map register bank with level reassembly
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module ptm_bank (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire ptm_pkg::ptm_bus_s             bus_i,
    output logic      [ptm_pkg::DATA_W-1:0]    rdata_o,
    output ptm_pkg::ptm_thr_s                  thr_o,
    output logic      [ptm_pkg::NUM_REGS-1:0]  written_o
);

    // decoded address: hit flag and storage index
    typedef struct packed {
        logic                      hit;
        logic [ptm_pkg::IDX_W-1:0] idx;
    } ptm_dec_s;

    logic [ptm_pkg::NUM_REGS-1:0][ptm_pkg::DATA_W-1:0] regs;
    ptm_dec_s                                          wdec;
    ptm_dec_s                                          rdec;
    logic                                              wr_hit;
    logic [ptm_pkg::DATA_W-1:0]                        rdata_nxt;
    ptm_pkg::ptm_thr_s                                 thr_nxt;
    logic [ptm_pkg::NUM_REGS-1:0]                      written_nxt;

    // map a byte address onto a storage index
    function automatic ptm_dec_s decode(input logic [ptm_pkg::ADDR_W-1:0] addr);
        ptm_dec_s d;
        d.hit = 1'b1;
        d.idx = 3'h0;
        unique case (addr)
            ptm_pkg::ADDR_TIMES: d.idx = 3'h0;
            ptm_pkg::ADDR_LVL_A: d.idx = 3'h1;
            ptm_pkg::ADDR_LVL_B: d.idx = 3'h2;
            ptm_pkg::ADDR_LVL_C: d.idx = 3'h3;
            ptm_pkg::ADDR_LVL_D: d.idx = 3'h4;
            ptm_pkg::ADDR_LVL_E: d.idx = 3'h5;
            default:             d.hit = 1'b0;
        endcase
        return d;
    endfunction

    // address decode for both strobes
    assign wdec   = decode(bus_i.addr);
    assign rdec   = decode(bus_i.addr);
    assign wr_hit = bus_i.wr && wdec.hit;

    // byte storage, no reset on the threshold fields
    ptm_regmem u_mem (
        .clk_i   (clk_i),
        .we_i    (wr_hit),     // [RL3]
        .widx_i  (wdec.idx),
        .wdata_i (bus_i.wdata),
        .regs_o  (regs)
    );

    // record which bytes the host has loaded since reset
    always_comb begin
        written_nxt = written_o;
        if (wr_hit) begin
            written_nxt[wdec.idx] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            written_o <= ptm_pkg::WRITTEN_RST;
        end else begin
            written_o <= written_nxt;
        end
    end

    // read mux: data only in the cycle after the read strobe
    always_comb begin
        rdata_nxt = ptm_pkg::RDATA_RST;
        if (bus_i.rd) begin
            if (rdec.hit) begin
                rdata_nxt = regs[rdec.idx];
            end else if (bus_i.addr == ptm_pkg::ADDR_STATUS) begin
                rdata_nxt = {2'h0, written_o};
            end else begin
                rdata_nxt = ptm_pkg::UNMAPPED_RD;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= ptm_pkg::RDATA_RST;
        end else begin
            rdata_o <= rdata_nxt;
        end
    end

    // delta time codes and their microsecond values
    always_comb begin
        thr_nxt        = '0;
        thr_nxt.code11 = regs[0][ptm_pkg::T11_LSB +: ptm_pkg::CODE_W]; // [RL1]
        thr_nxt.code12 = regs[0][ptm_pkg::T12_LSB +: ptm_pkg::CODE_W]; // [RL2]
        thr_nxt.us11   = ptm_pkg::dt_us(thr_nxt.code11);               // [RL1]
        thr_nxt.us12   = ptm_pkg::dt_us(thr_nxt.code12);               // [RL2]
        // whole levels
        thr_nxt.level[0] = regs[1][ptm_pkg::L1_LSB +: 5];              // [RL4]
        thr_nxt.level[2] = regs[2][ptm_pkg::L3_LSB +: 5];              // [RL6]
        thr_nxt.level[5] = regs[4][ptm_pkg::L6_LSB +: 5];              // [RL9]
        thr_nxt.level[7] = regs[5][ptm_pkg::L8_LSB +: 5];              // [RL11]
        // split levels, lower address gives the upper bits
        thr_nxt.level[1] = {regs[1][ptm_pkg::L2_HI_LSB +: 3],
                            regs[2][ptm_pkg::L2_LO_LSB +: 2]};         // [RL5] [RL12]
        thr_nxt.level[3] = {regs[2][ptm_pkg::L4_HI_BIT],
                            regs[3][ptm_pkg::L4_LO_LSB +: 4]};         // [RL7] [RL12]
        thr_nxt.level[4] = {regs[3][ptm_pkg::L5_HI_LSB +: 4],
                            regs[4][ptm_pkg::L5_LO_BIT]};              // [RL8] [RL12]
        thr_nxt.level[6] = {regs[4][ptm_pkg::L7_HI_LSB +: 2],
                            regs[5][ptm_pkg::L7_LO_LSB +: 3]};         // [RL10] [RL12]
    end

    // registered threshold outputs, follow storage one cycle later
    always_ff @(posedge clk_i) begin
        thr_o <= thr_nxt; // [RL3]
    end

    // assertions on the bus, storage and outputs
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // a single write to one address, not repeated next cycle
    sequence wr_once(logic [ptm_pkg::ADDR_W-1:0] a);
        (bus_i.wr && bus_i.addr == a) ##1 !(bus_i.wr && bus_i.addr == a);
    endsequence

    // a write followed directly by a read of the same address
    sequence wr_then_rd(logic [ptm_pkg::ADDR_W-1:0] a);
        (bus_i.wr && bus_i.addr == a) ##1 (bus_i.rd && bus_i.addr == a);
    endsequence

    // point 11 code lands and decodes with exact figures
    t11_code_a: assert property ( // [RL1]
        wr_once(ptm_pkg::ADDR_TIMES) |-> ##1 (thr_o.code11 == $past(bus_i.wdata[7:4], 2)) &&
            (thr_o.code11 != 4'h9 || thr_o.us11 == 16'h07D0) &&
            (thr_o.code11 != 4'hF || thr_o.us11 == 16'h1F40))
        else $error("point 11 delta time wrong");

    // point 12 code lands and decodes with exact figures
    t12_code_a: assert property ( // [RL2]
        wr_once(ptm_pkg::ADDR_TIMES) |-> ##1 (thr_o.code12 == $past(bus_i.wdata[3:0], 2)) &&
            (thr_o.code12 != 4'h0 || thr_o.us12 == 16'h0064) &&
            (thr_o.code12 != 4'h4 || thr_o.us12 == 16'h0258))
        else $error("point 12 delta time wrong");

    // written byte reads back in the cycle after the read
    rd_back_a: assert property ( // [RL3]
        wr_then_rd(ptm_pkg::ADDR_LVL_C) |=> rdata_o == $past(bus_i.wdata, 2))
        else $error("register readback mismatch");

    // level 1 from the first level byte
    lvl1_field_a: assert property ( // [RL4]
        wr_once(ptm_pkg::ADDR_LVL_A) |-> ##1 thr_o.level[0] == $past(bus_i.wdata[7:3], 2))
        else $error("level 1 field wrong");

    // level 2 low bits from the second level byte
    lvl2_split_a: assert property ( // [RL5]
        wr_once(ptm_pkg::ADDR_LVL_B) |-> ##1 thr_o.level[1][1:0] == $past(bus_i.wdata[7:6], 2))
        else $error("level 2 low bits wrong");

    // level 3 from the second level byte
    lvl3_field_a: assert property ( // [RL6]
        wr_once(ptm_pkg::ADDR_LVL_B) |-> ##1 thr_o.level[2] == $past(bus_i.wdata[5:1], 2))
        else $error("level 3 field wrong");

    // level 4 top bit from the second level byte
    lvl4_split_a: assert property ( // [RL7]
        wr_once(ptm_pkg::ADDR_LVL_B) |-> ##1 thr_o.level[3][4] == $past(bus_i.wdata[0], 2))
        else $error("level 4 top bit wrong");

    // level 5 low bit from the fourth level byte
    lvl5_split_a: assert property ( // [RL8]
        wr_once(ptm_pkg::ADDR_LVL_D) |-> ##1 thr_o.level[4][0] == $past(bus_i.wdata[7], 2))
        else $error("level 5 low bit wrong");

    // level 6 from the fourth level byte
    lvl6_field_a: assert property ( // [RL9]
        wr_once(ptm_pkg::ADDR_LVL_D) |-> ##1 thr_o.level[5] == $past(bus_i.wdata[6:2], 2))
        else $error("level 6 field wrong");

    // level 7 low bits from the fifth level byte
    lvl7_split_a: assert property ( // [RL10]
        wr_once(ptm_pkg::ADDR_LVL_E) |-> ##1 thr_o.level[6][2:0] == $past(bus_i.wdata[7:5], 2))
        else $error("level 7 low bits wrong");

    // level 8 from the fifth level byte
    lvl8_field_a: assert property ( // [RL11]
        wr_once(ptm_pkg::ADDR_LVL_E) |-> ##1 thr_o.level[7] == $past(bus_i.wdata[4:0], 2))
        else $error("level 8 field wrong");

    // split levels joined with lower address bits on top
    split_join_a: assert property ( // [RL12]
        (!bus_i.wr && (&written_o)) |=> (thr_o.level[1] == {$past(regs[1][2:0]), $past(regs[2][7:6])}) &&
            (thr_o.level[3] == {$past(regs[2][0]), $past(regs[3][7:4])}) &&
            (thr_o.level[4] == {$past(regs[3][3:0]), $past(regs[4][7])}) &&
            (thr_o.level[6] == {$past(regs[4][1:0]), $past(regs[5][7:5])}))
        else $error("split level reassembly wrong");

    // status byte marks written registers one cycle after the write
    status_mark_a: assert property ( // [RL3]
        (bus_i.wr && bus_i.addr == ptm_pkg::ADDR_LVL_A) |=> written_o[1] ##1 written_o[1])
        else $error("written flag not set");

    // a read strobe on one address
    sequence rd_at(logic [ptm_pkg::ADDR_W-1:0] a);
        bus_i.rd && bus_i.addr == a;
    endsequence

    // reset clears read data and the written mask
    reset_clear_a: assert property (disable iff (1'b0)
        rst_i |=> rdata_o == 8'h00 && written_o == 6'h00)
        else $error("reset state wrong");

    // read data is zero unless a read was taken
    rd_idle_zero_a: assert property (
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not zero when idle");

    // unmapped reads return zero
    rd_unmapped_a: assert property (
        bus_i.rd && !rdec.hit && bus_i.addr != ptm_pkg::ADDR_STATUS
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // status read shows the written mask
    rd_status_a: assert property (
        rd_at(ptm_pkg::ADDR_STATUS) |=> rdata_o == {2'h0, $past(written_o)})
        else $error("status read wrong");

    // mapped read returns the stored byte one cycle later
    rd_level_a: assert property ( // [RL3]
        (bus_i.rd && rdec.hit && written_o[rdec.idx])
        |=> rdata_o == $past(regs[rdec.idx]))
        else $error("stored byte read wrong");

    // a taken write marks its byte as loaded
    wr_mark_a: assert property (
        wr_hit |=> written_o[$past(wdec.idx)])
        else $error("written mask bit missing");

    // written mask bits only fall on reset
    written_sticky_a: assert property (
        1'b1 |=> (written_o & $past(written_o)) == $past(written_o))
        else $error("written mask bit lost");

    // writes to unmapped addresses leave storage alone
    unmapped_wr_a: assert property (
        (bus_i.wr && !wdec.hit && (&written_o)) |=> regs == $past(regs))
        else $error("unmapped write changed storage");

    // thresholds hold while no write is taken
    thr_hold_a: assert property ( // [RL3]
        (&written_o && !bus_i.wr) |-> ##2 $stable(thr_o))
        else $error("threshold outputs moved without a write");

    // further point 11 codes against their microsecond figures
    dt_scale11_a: assert property ( // [RL1]
        written_o[0] |=> (thr_o.code11 != 4'h1 || thr_o.us11 == 16'h00C8) &&
            (thr_o.code11 != 4'h3 || thr_o.us11 == 16'h0190) &&
            (thr_o.code11 != 4'h6 || thr_o.us11 == 16'h03E8) &&
            (thr_o.code11 != 4'h8 || thr_o.us11 == 16'h0578) &&
            (thr_o.code11 != 4'hC || thr_o.us11 == 16'h0FA0) &&
            (thr_o.code11 != 4'hE || thr_o.us11 == 16'h1900))
        else $error("point 11 time scale wrong");

    // further point 12 codes against their microsecond figures
    dt_scale12_a: assert property ( // [RL2]
        written_o[0] |=> (thr_o.code12 != 4'h2 || thr_o.us12 == 16'h012C) &&
            (thr_o.code12 != 4'h5 || thr_o.us12 == 16'h0320) &&
            (thr_o.code12 != 4'h7 || thr_o.us12 == 16'h04B0) &&
            (thr_o.code12 != 4'hA || thr_o.us12 == 16'h0960) &&
            (thr_o.code12 != 4'hB || thr_o.us12 == 16'h0C80) &&
            (thr_o.code12 != 4'hD || thr_o.us12 == 16'h1450))
        else $error("point 12 time scale wrong");

    // level 2 top bits from the first level byte
    lvl2_top_a: assert property ( // [RL5]
        wr_once(ptm_pkg::ADDR_LVL_A) |-> ##1 thr_o.level[1][4:2] == $past(bus_i.wdata[2:0], 2))
        else $error("level 2 top bits wrong");

    // level 4 low bits from the third level byte
    lvl4_low_a: assert property ( // [RL7]
        wr_once(ptm_pkg::ADDR_LVL_C) |-> ##1 thr_o.level[3][3:0] == $past(bus_i.wdata[7:4], 2))
        else $error("level 4 low bits wrong");

    // level 5 top bits from the third level byte
    lvl5_top_a: assert property ( // [RL8]
        wr_once(ptm_pkg::ADDR_LVL_C) |-> ##1 thr_o.level[4][4:1] == $past(bus_i.wdata[3:0], 2))
        else $error("level 5 top bits wrong");

    // level 7 top bits from the fourth level byte
    lvl7_top_a: assert property ( // [RL10]
        wr_once(ptm_pkg::ADDR_LVL_D) |-> ##1 thr_o.level[6][4:3] == $past(bus_i.wdata[1:0], 2))
        else $error("level 7 top bits wrong");

endmodule

//--- rtl/ptm_pkg.sv
// constants, types and decode helpers for the preset 1 threshold map bank
//
// Contract
// (RL1) time bits 7:4 hold point 11 delta
// (RL2) time bits 3:0 hold point 12 delta
// (RL3) threshold fields have no reset value
// (RL4) level 1 sits in 65h bits 7:3
// (RL5) level 2 split: 65h 2:0, 66h 7:6
// (RL6) level 3 sits in 66h bits 5:1
// (RL7) level 4 split: 66h bit 0, 67h 7:4
// (RL8) level 5 split: 67h 3:0, 68h bit 7
// (RL9) level 6 sits in 68h bits 6:2
// (RL10) level 7 split: 68h 1:0, 69h 7:5
// (RL11) level 8 sits in 69h bits 4:0
// (RL12) split levels joined, lower address more significant
package ptm_pkg;

    // widths
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;
    localparam int LVL_W    = 5;
    localparam int CODE_W   = 4;
    localparam int US_W     = 16;
    localparam int NUM_REGS = 6;
    localparam int NUM_LVL  = 8;
    localparam int IDX_W    = 3;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_TIMES  = 8'h64;
    localparam logic [ADDR_W-1:0] ADDR_LVL_A  = 8'h65;
    localparam logic [ADDR_W-1:0] ADDR_LVL_B  = 8'h66;
    localparam logic [ADDR_W-1:0] ADDR_LVL_C  = 8'h67;
    localparam logic [ADDR_W-1:0] ADDR_LVL_D  = 8'h68;
    localparam logic [ADDR_W-1:0] ADDR_LVL_E  = 8'h69;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'hF0;

    // field positions (low bit of each slice)
    localparam int T11_LSB   = 4;
    localparam int T12_LSB   = 0;
    localparam int L1_LSB    = 3;
    localparam int L2_HI_LSB = 0;
    localparam int L2_LO_LSB = 6;
    localparam int L3_LSB    = 1;
    localparam int L4_HI_BIT = 0;
    localparam int L4_LO_LSB = 4;
    localparam int L5_HI_LSB = 0;
    localparam int L5_LO_BIT = 7;
    localparam int L6_LSB    = 2;
    localparam int L7_HI_LSB = 0;
    localparam int L7_LO_LSB = 5;
    localparam int L8_LSB    = 0;

    // reset values of the block's own state, and the unmapped read value
    localparam logic [NUM_REGS-1:0] WRITTEN_RST = 6'h00;
    localparam logic [DATA_W-1:0]   RDATA_RST   = 8'h00;
    localparam logic [DATA_W-1:0]   UNMAPPED_RD = 8'h00;

    // delta time in microseconds for each 4-bit code
    localparam logic [15:0][US_W-1:0] DT_US_TABLE = {
        16'h1F40, 16'h1900, 16'h1450, 16'h0FA0,
        16'h0C80, 16'h0960, 16'h07D0, 16'h0578,
        16'h04B0, 16'h03E8, 16'h0320, 16'h0258,
        16'h0190, 16'h012C, 16'h00C8, 16'h0064
    };

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ptm_bus_s;

    // reassembled threshold map
    typedef struct packed {
        logic [NUM_LVL-1:0][LVL_W-1:0] level;
        logic [CODE_W-1:0]             code11;
        logic [CODE_W-1:0]             code12;
        logic [US_W-1:0]               us11;
        logic [US_W-1:0]               us12;
    } ptm_thr_s;

    // code to microseconds lookup
    function automatic logic [US_W-1:0] dt_us(input logic [CODE_W-1:0] code);
        dt_us = DT_US_TABLE[code];
    endfunction

endpackage

//--- rtl/ptm_regmem.sv
// storage bytes of the threshold bank, deliberately without reset
`timescale 1ns/10ps
module ptm_regmem (
    input  wire logic                                          clk_i,
    input  wire logic                                          we_i,
    input  wire logic [ptm_pkg::IDX_W-1:0]                     widx_i,
    input  wire logic [ptm_pkg::DATA_W-1:0]                    wdata_i,
    output logic      [ptm_pkg::NUM_REGS-1:0][ptm_pkg::DATA_W-1:0] regs_o
);

    // byte write; contents unknown until the host writes them
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            regs_o[widx_i] <= wdata_i; // [RL3]
        end
    end

endmodule

//--- verif/test_preset1_threshold_map_bank.sv
// self-checking bench for the preset 1 threshold map bank
`timescale 1ns/10ps
module test_preset1_threshold_map_bank;
    logic                         clk_i;
    logic                         rst_i;
    ptm_pkg::ptm_bus_s            bus_r;
    logic [ptm_pkg::DATA_W-1:0]   rdata_o;
    ptm_pkg::ptm_thr_s            thr_o;
    logic [ptm_pkg::NUM_REGS-1:0] written_o;
    logic [7:0]                   base [0:5];
    logic [7:0]                   b    [0:5];
    logic [4:0]                   lx   [0:7];
    logic [15:0]                  us_tab [0:15];
    int                           error_cnt;
    int                           num_checks;

    ptm_bank dut (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .bus_i     (bus_r),
        .rdata_o   (rdata_o),
        .thr_o     (thr_o),
        .written_o (written_o)
    );

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // one bus cycle, launched just after a rising edge
    task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_r <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask

    // bus left idle for n cycles
    task automatic idle(input int n);
        repeat (n) drive(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read one byte, answer sampled in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        drive(1'b0, 1'b1, a, 8'h00);
        idle(1);
        #1;
        chk({8'h00, rdata_o}, {8'h00, exp});
    endtask

    // verdict and end of run
    task automatic end_sim;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // expected levels from the stored bytes, lower address gives upper bits
    task automatic calc_levels;
        lx[0] = b[1][7:3];
        lx[1] = {b[1][2:0], b[2][7:6]};
        lx[2] = b[2][5:1];
        lx[3] = {b[2][0], b[3][7:4]};
        lx[4] = {b[3][3:0], b[4][7]};
        lx[5] = b[4][6:2];
        lx[6] = {b[4][1:0], b[5][7:5]};
        lx[7] = b[5][4:0];
    endtask

    // hang guard
    initial begin
        #50000;
        error_cnt++;
        end_sim();
    end

    // main sequence
    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst_i = 1'b1;
        bus_r = '0;
        base = '{8'hA5, 8'h3C, 8'h96, 8'hE1, 8'h5B, 8'hC7};
        us_tab = '{16'h0064, 16'h00C8, 16'h012C, 16'h0190, 16'h0258, 16'h0320, 16'h03E8, 16'h04B0,
                   16'h0578, 16'h07D0, 16'h0960, 16'h0C80, 16'h0FA0, 16'h1450, 16'h1900, 16'h1F40};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk({8'h00, rdata_o}, 16'h0000);
        chk({10'h000, written_o}, 16'h0000);
        // every byte written back to back, read back, then reassembled
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 6; i++) begin
                b[i] = base[i] ^ {8{p[0]}};
                drive(1'b1, 1'b0, 8'h64 + i[7:0], b[i]);
            end
            for (int i = 0; i < 6; i++) begin
                rd_chk(8'h64 + i[7:0], b[i]);
            end
            chk({10'h000, written_o}, 16'h003F);
            calc_levels();
            idle(2);
            #1;
            for (int i = 0; i < 8; i++) begin
                chk({11'h000, thr_o.level[i]}, {11'h000, lx[i]});
            end
            chk({12'h000, thr_o.code11}, {12'h000, b[0][7:4]});
            chk({12'h000, thr_o.code12}, {12'h000, b[0][3:0]});
        end
        // unmapped and read-only places leave the bank alone
        drive(1'b1, 1'b0, 8'h6A, 8'hFF);
        drive(1'b1, 1'b0, 8'hF0, 8'hFF);
        rd_chk(8'h6A, 8'h00);
        rd_chk(8'hF0, 8'h3F);
        rd_chk(8'h69, b[5]);
        idle(1);
        #1;
        chk({8'h00, rdata_o}, 16'h0000);
        // write then read of one byte in consecutive cycles
        b[3] = 8'h5A;
        drive(1'b1, 1'b0, 8'h67, b[3]);
        rd_chk(8'h67, b[3]);
        calc_levels();
        idle(1);
        #1;
        chk({11'h000, thr_o.level[3]}, {11'h000, lx[3]});
        chk({11'h000, thr_o.level[4]}, {11'h000, lx[4]});
        // every delta time code on both points
        for (int c = 0; c < 16; c++) begin
            drive(1'b1, 1'b0, 8'h64, {c[3:0], ~c[3:0]});
            idle(3);
            #1;
            chk({12'h000, thr_o.code11}, {12'h000, c[3:0]});
            chk(thr_o.us11, us_tab[c]);
            chk({12'h000, thr_o.code12}, {12'h000, ~c[3:0]});
            chk(thr_o.us12, us_tab[15-c]);
        end
        rd_chk(8'h64, 8'hF0);
        end_sim();
    end
endmodule
